// file: src/echo_peak_level_monitor.v
// Peak-level register bank for two echo cancellers, reached over APB
//
// How it works
// - Each canceller's send-in peak is measured and readable by software.
// - Every peak value is a 16-bit two's complement linear word.
// - Each peak splits into two byte registers, one pair per signal and canceller.
// - Register 2 of a pair holds bits 15..8, register 1 bits 7..0.
// - Each canceller's receive-in peak is reported as a high/low byte pair.
// - Send-in bytes sit at 0x0E/0x0F for the first, 0x2E/0x2F for the second.
// - Error bytes: first low at 0x10; second low 0x30, high 0x31.
// - Second canceller's receive-in high byte sits at 0x2D.
`timescale 1ns/1ps
module echo_peak_level_monitor (
	input wire ref_clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire firstCancellerStrobe,
	input wire [15:0] firstCancellerRecvin,
	input wire [15:0] firstCancellerSendin,
	input wire [15:0] firstCancellerError,
	input wire secondCancellerStrobe,
	input wire [15:0] secondCancellerRecvin,
	input wire [15:0] secondCancellerSendin,
	input wire [15:0] secondCancellerError
);
`include "echo_peak_regs.vh"

	// ****************************************************************
	// Decode helpers
	// ****************************************************************

	// Returns {hit, highByte, tracker[2:0]} for a peak register index
	function [4:0] peakMap;
		input [7:0] idx;
		begin
			case (idx)
				`IDX_A_RECVIN_LOW: peakMap = {2'b10, `TRK_A_RECVIN};
				`IDX_A_RECVIN_HIGH: peakMap = {2'b11, `TRK_A_RECVIN};
				`IDX_A_SENDIN_LOW: peakMap = {2'b10, `TRK_A_SENDIN};
				`IDX_A_SENDIN_HIGH: peakMap = {2'b11, `TRK_A_SENDIN};
				`IDX_A_ERROR_LOW: peakMap = {2'b10, `TRK_A_ERROR};
				`IDX_A_ERROR_HIGH: peakMap = {2'b11, `TRK_A_ERROR};
				`IDX_B_RECVIN_LOW: peakMap = {2'b10, `TRK_B_RECVIN};
				`IDX_B_RECVIN_HIGH: peakMap = {2'b11, `TRK_B_RECVIN};
				`IDX_B_SENDIN_LOW: peakMap = {2'b10, `TRK_B_SENDIN};
				`IDX_B_SENDIN_HIGH: peakMap = {2'b11, `TRK_B_SENDIN};
				`IDX_B_ERROR_LOW: peakMap = {2'b10, `TRK_B_ERROR};
				`IDX_B_ERROR_HIGH: peakMap = {2'b11, `TRK_B_ERROR};
				default: peakMap = 5'h00;
			endcase
		end
	endfunction

	// Picks one byte of a 16-bit peak word
	function [7:0] peakByte;
		input [15:0] value;
		input high;
		begin
			if (high) begin
				peakByte = value[15:8];
			end else begin
				peakByte = value[7:0];
			end
		end
	endfunction

	// One-hot select line for a tracker number
	function [`TRK_COUNT-1:0] trackerBit;
		input [2:0] trk;
		begin
			trackerBit = {{(`TRK_COUNT-1){1'b0}}, 1'b1} << trk;
		end
	endfunction

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire [7:0] regIndex;
	wire aligned;
	wire [4:0] mapped;
	wire peakHit;
	wire peakHigh;
	wire [2:0] peakSel;
	wire ctrlHit;
	wire statusHit;
	wire hit;
	wire writeFire;

	// Accesses off a word boundary or above the map are refused, not folded onto a register
	assign regIndex = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	assign mapped = peakMap(regIndex);
	assign peakHit = aligned & mapped[4];
	assign peakHigh = mapped[3];
	assign peakSel = mapped[2:0];
	assign ctrlHit = aligned & (regIndex == `IDX_CONTROL);
	assign statusHit = aligned & (regIndex == `IDX_STATUS);
	assign hit = peakHit | ctrlHit | statusHit;

	// A write takes effect only on the edge that completes the transfer
	assign writeFire = psel & penable & pready & pwrite & hit;

	// ****************************************************************
	// Control register
	// ****************************************************************
	reg [7:0] ctrl_q;
	reg [7:0] ctrl_d;
	wire clearAll;

	always @* begin
		ctrl_d = ctrl_q;
		if (writeFire && ctrlHit) begin
			// Clear bit is a command and is never stored
			ctrl_d = pwdata[7:0] & ~(8'h01 << `CTRL_CLEAR_BIT);
		end
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= `CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Clear is a one-cycle command taken straight from the write data
	assign clearAll = writeFire & ctrlHit & pwdata[`CTRL_CLEAR_BIT];

	// ****************************************************************
	// Peak trackers
	// ****************************************************************
	wire [`TRK_COUNT-1:0] roseBus;
	wire [15:0] peakARecvin;
	wire [15:0] peakASendin;
	wire [15:0] peakAError;
	wire [15:0] peakBRecvin;
	wire [15:0] peakBSendin;
	wire [15:0] peakBError;
	wire [3:0] decayShift;
	wire runA;
	wire runB;
	wire [`TRK_COUNT-1:0] loadSel;
	wire [`TRK_COUNT-1:0] loadLowBus;
	wire [`TRK_COUNT-1:0] loadHighBus;

	// Run bits gate sampling per canceller; a stopped canceller keeps its last peaks
	assign decayShift = ctrl_q[`CTRL_DECAY_MSB:`CTRL_DECAY_LSB];
	assign runA = ctrl_q[`CTRL_RUN_A_BIT];
	assign runB = ctrl_q[`CTRL_RUN_B_BIT];

	// A software byte load reaches only the tracker that the address selects
	assign loadSel = {`TRK_COUNT{writeFire & peakHit}} & trackerBit(peakSel);
	assign loadLowBus = loadSel & {`TRK_COUNT{~peakHigh}};
	assign loadHighBus = loadSel & {`TRK_COUNT{peakHigh}};

	// Peaks are magnitudes; a load from software takes the bus byte as it is
	// First canceller, receive-in
	peak_tracker trackerARecvin (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(runA),
		.sampleValid(firstCancellerStrobe),
		.sample(firstCancellerRecvin),
		.decayShift(decayShift),
		.clearPeak(clearAll),
		.loadLow(loadLowBus[`TRK_A_RECVIN]),
		.loadHigh(loadHighBus[`TRK_A_RECVIN]),
		.loadByte(pwdata[7:0]),
		.peak(peakARecvin),
		.rose(roseBus[`TRK_A_RECVIN])
	);

	// First canceller, send-in
	peak_tracker trackerASendin (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(runA),
		.sampleValid(firstCancellerStrobe),
		.sample(firstCancellerSendin),
		.decayShift(decayShift),
		.clearPeak(clearAll),
		.loadLow(loadLowBus[`TRK_A_SENDIN]),
		.loadHigh(loadHighBus[`TRK_A_SENDIN]),
		.loadByte(pwdata[7:0]),
		.peak(peakASendin),
		.rose(roseBus[`TRK_A_SENDIN])
	);

	// First canceller, error after cancellation
	peak_tracker trackerAError (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(runA),
		.sampleValid(firstCancellerStrobe),
		.sample(firstCancellerError),
		.decayShift(decayShift),
		.clearPeak(clearAll),
		.loadLow(loadLowBus[`TRK_A_ERROR]),
		.loadHigh(loadHighBus[`TRK_A_ERROR]),
		.loadByte(pwdata[7:0]),
		.peak(peakAError),
		.rose(roseBus[`TRK_A_ERROR])
	);

	// Second canceller, receive-in
	peak_tracker trackerBRecvin (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(runB),
		.sampleValid(secondCancellerStrobe),
		.sample(secondCancellerRecvin),
		.decayShift(decayShift),
		.clearPeak(clearAll),
		.loadLow(loadLowBus[`TRK_B_RECVIN]),
		.loadHigh(loadHighBus[`TRK_B_RECVIN]),
		.loadByte(pwdata[7:0]),
		.peak(peakBRecvin),
		.rose(roseBus[`TRK_B_RECVIN])
	);

	// Second canceller, send-in
	peak_tracker trackerBSendin (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(runB),
		.sampleValid(secondCancellerStrobe),
		.sample(secondCancellerSendin),
		.decayShift(decayShift),
		.clearPeak(clearAll),
		.loadLow(loadLowBus[`TRK_B_SENDIN]),
		.loadHigh(loadHighBus[`TRK_B_SENDIN]),
		.loadByte(pwdata[7:0]),
		.peak(peakBSendin),
		.rose(roseBus[`TRK_B_SENDIN])
	);

	// Second canceller, error after cancellation
	peak_tracker trackerBError (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(runB),
		.sampleValid(secondCancellerStrobe),
		.sample(secondCancellerError),
		.decayShift(decayShift),
		.clearPeak(clearAll),
		.loadLow(loadLowBus[`TRK_B_ERROR]),
		.loadHigh(loadHighBus[`TRK_B_ERROR]),
		.loadByte(pwdata[7:0]),
		.peak(peakBError),
		.rose(roseBus[`TRK_B_ERROR])
	);

	// ****************************************************************
	// Status register: sticky new-peak flags, write one to clear
	// ****************************************************************
	// One flag per tracker, in tracker numbering
	reg [`TRK_COUNT-1:0] flags_q;
	reg [`TRK_COUNT-1:0] flags_d;

	always @* begin
		flags_d = flags_q;
		if (writeFire && statusHit) begin
			flags_d = flags_q & ~pwdata[`TRK_COUNT-1:0];
		end
		// A rise in the clearing cycle is kept
		flags_d = flags_d | roseBus;
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= {`TRK_COUNT{1'b0}};
		end else begin
			flags_q <= flags_d;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	reg [31:0] readData;
	reg [15:0] selectedPeak;

	// No snapshot of a pair: a sample between the two byte reads can mix old and new
	always @* begin
		case (peakSel)
			`TRK_A_RECVIN: begin
				selectedPeak = peakARecvin;
			end
			`TRK_A_SENDIN: begin
				selectedPeak = peakASendin;
			end
			`TRK_A_ERROR: begin
				selectedPeak = peakAError;
			end
			`TRK_B_RECVIN: begin
				selectedPeak = peakBRecvin;
			end
			`TRK_B_SENDIN: begin
				selectedPeak = peakBSendin;
			end
			`TRK_B_ERROR: begin
				selectedPeak = peakBError;
			end
			default: begin
				selectedPeak = `PEAK_RESET;
			end
		endcase
	end

	always @* begin
		readData = 32'h00000000;
		if (peakHit) begin
			readData[7:0] = peakByte(selectedPeak, peakHigh);
		end else if (ctrlHit) begin
			readData[7:0] = ctrl_q;
		end else if (statusHit) begin
			readData[`TRK_COUNT-1:0] = flags_q;
		end
	end

	// The answer stage adds one wait state and registers every bus output
	apb_answer answer (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.psel(psel),
		.penable(penable),
		.readData(readData),
		.hit(hit),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);
endmodule // echo_peak_level_monitor

// file: src/echo_peak_regs.vh
// Register indices, field positions and reset values of the peak-level monitor
`ifndef ECHO_PEAK_REGS_VH
`define ECHO_PEAK_REGS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_A_RECVIN_LOW 8'h0C
`define IDX_A_RECVIN_HIGH 8'h0D
`define IDX_A_SENDIN_LOW 8'h0E
`define IDX_A_SENDIN_HIGH 8'h0F
`define IDX_A_ERROR_LOW 8'h10
`define IDX_A_ERROR_HIGH 8'h11
`define IDX_B_RECVIN_LOW 8'h2C
`define IDX_B_RECVIN_HIGH 8'h2D
`define IDX_B_SENDIN_LOW 8'h2E
`define IDX_B_SENDIN_HIGH 8'h2F
`define IDX_B_ERROR_LOW 8'h30
`define IDX_B_ERROR_HIGH 8'h31
`define IDX_CONTROL 8'h3E
`define IDX_STATUS 8'h3F

// ****************************************************************
// Tracker numbering
// ****************************************************************
`define TRK_A_RECVIN 3'h0
`define TRK_A_SENDIN 3'h1
`define TRK_A_ERROR 3'h2
`define TRK_B_RECVIN 3'h3
`define TRK_B_SENDIN 3'h4
`define TRK_B_ERROR 3'h5
`define TRK_COUNT 6

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define CTRL_RUN_A_BIT 0
`define CTRL_RUN_B_BIT 1
`define CTRL_CLEAR_BIT 2
`define CTRL_DECAY_LSB 4
`define CTRL_DECAY_MSB 7
`define CTRL_RESET 8'h03
`define PEAK_RESET 16'h0000
`define PEAK_MAX 16'h7FFF
`define PEAK_MIN 16'h8000

`endif

// file: src/peak_tracker.v
// Peak-level tracker for one monitored 16-bit two's complement signal
`timescale 1ns/1ps
module peak_tracker (
	input wire ref_clk,
	input wire rstn,
	input wire run,
	input wire sampleValid,
	input wire [15:0] sample,
	input wire [3:0] decayShift,
	input wire clearPeak,
	input wire loadLow,
	input wire loadHigh,
	input wire [7:0] loadByte,
	output wire [15:0] peak,
	output wire rose
);
`include "echo_peak_regs.vh"

	reg [15:0] peak_q;
	reg [15:0] peak_d;
	reg rose_q;
	reg rose_d;
	reg [15:0] magnitude;
	reg [15:0] decayed;

	// ****************************************************************
	// Magnitude with decay
	// ****************************************************************
	always @* begin
		// Most negative input cannot be negated in 16 bits, so it saturates
		if (sample == `PEAK_MIN) begin
			magnitude = `PEAK_MAX;
		end else if (sample[15]) begin
			magnitude = (~sample) + 16'h0001;
		end else begin
			magnitude = sample;
		end
		if (decayShift == 4'h0) begin
			decayed = peak_q;
		end else begin
			decayed = peak_q - (peak_q >> decayShift);
		end
		peak_d = peak_q;
		rose_d = 1'b0;
		if (clearPeak) begin
			peak_d = `PEAK_RESET;
		end else if (loadLow) begin
			peak_d = {peak_q[15:8], loadByte};
		end else if (loadHigh) begin
			peak_d = {loadByte, peak_q[7:0]};
		end else if (run && sampleValid) begin
			if (magnitude > decayed) begin
				peak_d = magnitude;
				rose_d = (magnitude > peak_q);
			end else begin
				peak_d = decayed;
			end
		end
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			peak_q <= `PEAK_RESET;
			rose_q <= 1'b0;
		end else begin
			peak_q <= peak_d;
			rose_q <= rose_d;
		end
	end

	assign peak = peak_q;
	assign rose = rose_q;
endmodule // peak_tracker

// file: src/apb_answer.v
// APB answer stage: one wait state, registered read data and error
`timescale 1ns/1ps
module apb_answer (
	input wire ref_clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire [31:0] readData,
	input wire hit,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr
);
	reg pready_q;
	reg pslverr_q;
	reg [31:0] prdata_q;
	wire starting;

	// Ready rises on the second access cycle and falls right after it
	assign starting = psel & penable & ~pready_q;

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= starting;
			if (starting) begin
				pslverr_q <= ~hit;
				prdata_q <= hit ? readData : 32'h00000000;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule // apb_answer

// file: verification/echo_peak_level_monitor_props.sv
// Concurrent checks on the register port of the peak-level monitor
`timescale 1ns/1ps
module echo_peak_level_monitor_props (
	input wire ref_clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	// ****************************************************************
	// Address decode seen from the bus
	// ****************************************************************
	wire aligned = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_byte_wide; pready |-> (prdata[31:8] == 24'h000000); endproperty
	a_byte_wide: assert property (p_byte_wide) else $error("upper read bits set");
	property p_sendin_mapped;
		pready && aligned && (paddr[9:2] inside {8'h0E, 8'h0F, 8'h2E, 8'h2F}) |-> !pslverr;
	endproperty
	a_sendin_mapped: assert property (p_sendin_mapped) else $error("send-in byte refused");
	property p_error_mapped;
		pready && aligned && (paddr[9:2] inside {8'h10, 8'h30, 8'h31}) |-> !pslverr;
	endproperty
	a_error_mapped: assert property (p_error_mapped) else $error("error byte refused");
	property p_recvin_mapped; pready && aligned && (paddr[9:2] == 8'h2D) |-> !pslverr; endproperty
	a_recvin_mapped: assert property (p_recvin_mapped) else $error("recv-in byte refused");
	// One wait state keeps every register reachable with a fixed answer time
	property p_answer_delay; $rose(penable) && psel |=> pready; endproperty
	a_answer_delay: assert property (p_answer_delay) else $error("answer late");
	property p_ready_one; pready |=> !pready; endproperty
	a_ready_one: assert property (p_ready_one) else $error("pready held too long");
	property p_ready_in_access; pready |-> psel && penable; endproperty
	a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
	property p_err_with_ready; pslverr |-> pready; endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
endmodule // echo_peak_level_monitor_props

bind echo_peak_level_monitor echo_peak_level_monitor_props echo_peak_level_monitor_props_inst (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr)
);

// file: verification/testbench.sv
// Self-checking testbench for the peak-level monitor
`timescale 1ns/1ps
`include "echo_peak_regs.vh"
module testbench;
	reg ref_clk = 1'b0;
	reg rstn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h00000000;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	reg strobeA = 1'b0;
	reg strobeB = 1'b0;
	reg [15:0] smp [0:5];
	integer error_cnt = 0;
	integer cmp_count = 0;
	reg [31:0] rd;
	reg err;

	echo_peak_level_monitor echo_peak_level_monitor_inst (
		.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.firstCancellerStrobe(strobeA), .firstCancellerRecvin(smp[0]),
		.firstCancellerSendin(smp[1]), .firstCancellerError(smp[2]),
		.secondCancellerStrobe(strobeB), .secondCancellerRecvin(smp[3]),
		.secondCancellerSendin(smp[4]), .secondCancellerError(smp[5])
	);

	always #25 ref_clk = ~ref_clk;

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task check(input string what, input [31:0] exp, input [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Magnitude saturates because the most negative word has no positive twin
	function [15:0] mag(input [15:0] v);
		mag = (v == 16'h8000) ? 16'h7FFF : (v[15] ? -v : v);
	endfunction

	task apb(input w, input [11:0] addr, input [7:0] wd);
		integer n;
		begin
			@(posedge ref_clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= addr;
			pwdata <= {24'h000000, wd};
			@(posedge ref_clk);
			penable <= 1'b1;
			n = 0;
			do begin
				@(posedge ref_clk);
				n++;
			end while (pready !== 1'b1 && n < 20);
			check("pready", 32'h1, {31'h0, pready});
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task strobe(input a, input b, input [95:0] vals);
		begin
			@(posedge ref_clk);
			for (int k = 0; k < 6; k++) smp[k] <= vals[16*k +: 16];
			strobeA <= a;
			strobeB <= b;
			@(posedge ref_clk);
			strobeA <= 1'b0;
			strobeB <= 1'b0;
		end
	endtask

	task read_pair(input [7:0] lowIdx, input [15:0] exp);
		begin
			apb(1'b0, {2'b00, lowIdx, 2'b00}, 8'h00);
			check("peak low byte", {24'h000000, exp[7:0]}, rd);
			apb(1'b0, {2'b00, lowIdx + 8'h01, 2'b00}, 8'h00);
			check("peak high byte", {24'h000000, exp[15:8]}, rd);
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_all_signals;
		begin
			strobe(1'b1, 1'b1, {16'hF001, 16'h2345, 16'h8000, 16'h0ABC, 16'hEDCC, 16'h0456});
			read_pair(`IDX_A_RECVIN_LOW, mag(16'h0456));
			read_pair(`IDX_A_SENDIN_LOW, mag(16'hEDCC));
			read_pair(`IDX_A_ERROR_LOW, mag(16'h0ABC));
			read_pair(`IDX_B_RECVIN_LOW, mag(16'h8000));
			read_pair(`IDX_B_SENDIN_LOW, mag(16'h2345));
			read_pair(`IDX_B_ERROR_LOW, mag(16'hF001));
			$display("test all_signals done");
		end
	endtask

	task t_independence;
		begin
			// Only the second canceller is strobed, so the first must keep its peaks
			strobe(1'b0, 1'b1, {16'h0001, 16'hD000, 16'h0002, 16'h7000, 16'h7000, 16'h7000});
			read_pair(`IDX_A_SENDIN_LOW, mag(16'hEDCC));
			read_pair(`IDX_B_SENDIN_LOW, 16'h3000);
			read_pair(`IDX_B_ERROR_LOW, mag(16'hF001));
			$display("test independence done");
		end
	endtask

	task t_write_unmapped;
		begin
			apb(1'b1, {2'b00, `IDX_A_SENDIN_HIGH, 2'b00}, 8'h5A);
			read_pair(`IDX_A_SENDIN_LOW, 16'h5A34);
			apb(1'b0, 12'h048, 8'h00);
			check("unmapped error", 32'h1, {31'h0, err});
			check("unmapped data", 32'h0, rd);
			apb(1'b0, 12'h03B, 8'h00);
			check("misaligned error", 32'h1, {31'h0, err});
			$display("test write_unmapped done");
		end
	endtask

	task t_control_status;
		begin
			apb(1'b0, {2'b00, `IDX_STATUS, 2'b00}, 8'h00);
			check("status after rises", 32'h3F, rd);
			apb(1'b1, {2'b00, `IDX_STATUS, 2'b00}, 8'h3F);
			apb(1'b0, {2'b00, `IDX_STATUS, 2'b00}, 8'h00);
			check("status cleared", 32'h00, rd);
			// First canceller stopped: its strobe must leave its peaks alone
			apb(1'b1, {2'b00, `IDX_CONTROL, 2'b00}, 8'h02);
			strobe(1'b1, 1'b1, {16'h0000, 16'h9000, 16'h0000, 16'h0000, 16'h7000, 16'h0000});
			read_pair(`IDX_A_SENDIN_LOW, 16'h5A34);
			read_pair(`IDX_B_SENDIN_LOW, mag(16'h9000));
			apb(1'b0, {2'b00, `IDX_STATUS, 2'b00}, 8'h00);
			check("status new peak", 32'h10, rd);
			// Clear empties every peak and is never stored
			apb(1'b1, {2'b00, `IDX_CONTROL, 2'b00}, 8'h06);
			apb(1'b0, {2'b00, `IDX_CONTROL, 2'b00}, 8'h00);
			check("control", 32'h02, rd);
			read_pair(`IDX_A_SENDIN_LOW, `PEAK_RESET);
			// Decay shift 1 halves a peak that no larger sample refreshes
			apb(1'b1, {2'b00, `IDX_CONTROL, 2'b00}, 8'h13);
			strobe(1'b1, 1'b0, {80'h0, 16'h0400});
			strobe(1'b1, 1'b0, 96'h0);
			read_pair(`IDX_A_RECVIN_LOW, 16'h0200);
			$display("test control_status done");
		end
	endtask

	task t_reset;
		begin
			@(posedge ref_clk);
			rstn <= 1'b0;
			repeat (2) @(posedge ref_clk);
			rstn <= 1'b1;
			apb(1'b0, {2'b00, `IDX_CONTROL, 2'b00}, 8'h00);
			check("control after reset", {24'h000000, `CTRL_RESET}, rd);
			read_pair(`IDX_A_RECVIN_LOW, `PEAK_RESET);
			apb(1'b0, {2'b00, `IDX_STATUS, 2'b00}, 8'h00);
			check("status after reset", 32'h00, rd);
			$display("test reset done");
		end
	endtask

	task print_verdict;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
			if (error_cnt == 0 && cmp_count > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	initial begin
		for (int k = 0; k < 6; k++) smp[k] = 16'h0000;
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		t_all_signals();
		t_independence();
		t_write_unmapped();
		t_control_status();
		t_reset();
		print_verdict();
	end

	// 43 transfers of a few cycles each; this leaves a wide margin
	initial begin
		#(50 * 4000);
		error_cnt++;
		print_verdict();
	end
endmodule // testbench
